// ---- design/base_clock_gen.sv ----
// Purpose: Base clock tick from the system clock, mode-select divider
// Assumes: Synchronous reset copy from the top
// Notes:   One-cycle tick per base clock period
`timescale 1ns/10ps
`default_nettype none
module base_clock_gen
(
  input  wire logic clock_i,      // System clock
  input  wire logic rst_n_i,      // Synchronised reset
  input  wire logic mode_sel_i,   // Mode-select level
  output logic      base_tick_o   // Base clock tick
);
  logic [poll_pkg::DIV_W-1:0] cnt_ff;
  wire  [poll_pkg::DIV_W-1:0] div_last = mode_sel_i ?
        poll_pkg::DIV_W'(poll_pkg::BASE_DIV_HI - 1) :
        poll_pkg::DIV_W'(poll_pkg::BASE_DIV_LO - 1);
  wire  wrap = (cnt_ff >= div_last);
  wire  [poll_pkg::DIV_W-1:0] nxt_cnt = wrap ? '0 : cnt_ff + 1'b1;

  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;

  assign base_tick_o = wrap;
endmodule
`default_nettype wire

// ---- design/ext_clock_gen.sv ----
// Purpose: Extended clock tick as 8, 4, 2 or 1 base clock periods
// Assumes: Base tick is one cycle wide
// Notes:   Range changes take effect at the next base tick
`timescale 1ns/10ps
`default_nettype none
module ext_clock_gen
(
  input  wire logic       clock_i,     // System clock
  input  wire logic       rst_n_i,     // Synchronised reset
  input  wire logic       base_tick_i, // Base clock tick
  input  wire logic [1:0] range_i,     // Baud range select
  output logic            ext_tick_o   // Extended clock tick
);
  logic [3:0] cnt_ff;
  logic [3:0] div;
  always_comb
  begin
    case (range_i)
      poll_pkg::RANGE_0: div = poll_pkg::XCLK_DIV_0;
      poll_pkg::RANGE_1: div = poll_pkg::XCLK_DIV_1;
      poll_pkg::RANGE_2: div = poll_pkg::XCLK_DIV_2;
      default:           div = poll_pkg::XCLK_DIV_3;
    endcase
  end
  wire wrap = base_tick_i && (cnt_ff >= div - 4'h1);
  wire [3:0] nxt_cnt = !base_tick_i ? cnt_ff : (wrap ? 4'h0 : cnt_ff + 4'h1);

  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= nxt_cnt;

  assign ext_tick_o = wrap;
endmodule
`default_nettype wire

// ---- design/polling_bit_check_controller.sv ----
// Purpose: Sleep, start-up and bit-check polling sequencer
// Assumes: Demodulator output and config fields synchronous to clock_i
// Notes:   Register bus holds the operating and limit configuration
`timescale 1ns/10ps
`default_nettype none
module polling_bit_check_controller
(
  input  wire logic       clock_i,              // System clock, 125 MHz
  input  wire logic       reset_n_i,            // Async reset, active low
  input  wire logic       mode_sel_i,           // Mode-select pin level
  input  wire logic       demod_i,              // Demodulator output
  input  wire logic       return_poll_i,        // Pulse: back to polling
  input  wire logic [1:0] reg_addr_i,           // Register index
  input  wire logic [7:0] reg_wdata_i,          // Write data
  input  wire logic       reg_wr_i,             // Write strobe
  input  wire logic       reg_rd_i,             // Read strobe
  output logic [7:0]      reg_rdata_o,          // Read data, cycle after
  output logic            activity_indicator_o, // High when active
  output logic            signal_enable_o,      // Signal processing on
  output logic            receiving_o,          // In receiving mode
  output logic            data_o                // Routed data output
);
  logic rst_s1_ff;
  logic rst_n;
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      rst_s1_ff <= 1'b0;
      rst_n     <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_n     <= rst_s1_ff;
    end

  logic base_tick;
  logic ext_tick;
  logic [7:0] cfg_ff;      // [1:0] range, [3:2] bits, [4] ext, unused above
  logic [4:0] sleep_ff;
  logic [4:0] lim_min_ff;
  logic [4:0] lim_max_ff;
  logic       sleep_written_ff;

  base_clock_gen u_base
  (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n),
    .mode_sel_i  (mode_sel_i),
    .base_tick_o (base_tick)
  );

  ext_clock_gen u_ext
  (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n),
    .base_tick_i (base_tick),
    .range_i     (cfg_ff[1:0]),
    .ext_tick_o  (ext_tick)
  );

  // Register writes; the sleep field is written through the status index
  wire wr_cfg   = reg_wr_i && (reg_addr_i == poll_pkg::ADDR_CONFIG);
  wire wr_min   = reg_wr_i && (reg_addr_i == poll_pkg::ADDR_LIMIT_MIN);
  wire wr_max   = reg_wr_i && (reg_addr_i == poll_pkg::ADDR_LIMIT_MAX);
  wire wr_sleep = reg_wr_i && (reg_addr_i == poll_pkg::ADDR_STATUS);

  always_ff @(posedge clock_i or negedge rst_n)
    if (!rst_n)
    begin
      cfg_ff           <= 8'h00;
      sleep_ff         <= poll_pkg::SLEEP_FOREVER;
      lim_min_ff       <= poll_pkg::LIM_MIN_RST;
      lim_max_ff       <= poll_pkg::LIM_MAX_RST;
      sleep_written_ff <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
      begin
        cfg_ff <= {3'h0, reg_wdata_i[4:0]};
      end
      if (wr_sleep)
      begin
        sleep_ff <= reg_wdata_i[4:0];
      end
      if (wr_min)
        lim_min_ff <= reg_wdata_i[4:0];
      if (wr_max)
        lim_max_ff <= reg_wdata_i[4:0];
      sleep_written_ff <= wr_sleep;
    end

  wire [1:0] bit_sel       = cfg_ff[3:2];
  wire       ext_sleep_bit = cfg_ff[4];
  wire [3:0] sleep_factor  = ext_sleep_bit ? poll_pkg::SLEEP_FACTOR_EXT :
                                             poll_pkg::SLEEP_FACTOR_STD;
  wire [4:0] checks_needed = (bit_sel == 2'h0) ? poll_pkg::CHECKS_0 :
                             (bit_sel == 2'h1) ? poll_pkg::CHECKS_3 :
                             (bit_sel == 2'h2) ? poll_pkg::CHECKS_6 :
                                                 poll_pkg::CHECKS_9;

  // Sleep length in base ticks; product fits 5+3+10 bits
  wire [poll_pkg::SLEEP_CNT_W-1:0] sleep_len =
    poll_pkg::SLEEP_CNT_W'(sleep_ff) * poll_pkg::SLEEP_CNT_W'(sleep_factor) *
    poll_pkg::SLEEP_CNT_W'(poll_pkg::SLEEP_UNIT_BASE);

  poll_pkg::poll_state_e state_ff;
  poll_pkg::poll_state_e nxt_state;
  logic [poll_pkg::SLEEP_CNT_W-1:0] tcnt_ff;
  logic [poll_pkg::SLEEP_CNT_W-1:0] nxt_tcnt;
  logic [poll_pkg::CV_W-1:0]        cv_ff;
  logic [poll_pkg::CV_W-1:0]        nxt_cv;
  logic [4:0]                       pass_ff;
  logic [4:0]                       nxt_pass;
  logic                             demod_q_ff;

  wire edge_seen  = ext_tick && (demod_i != demod_q_ff);
  wire [poll_pkg::CV_W-1:0] cv_inc = cv_ff + 6'h01;
  wire below_min  = cv_inc < {1'b0, lim_min_ff};
  wire at_max     = cv_inc >= {1'b0, lim_max_ff};
  wire forever_sl = (sleep_ff == poll_pkg::SLEEP_FOREVER);
  wire sleep_done = base_tick && !forever_sl && (tcnt_ff + 1'b1 >= sleep_len);
  wire start_done = base_tick &&
                    (tcnt_ff + 1'b1 >= poll_pkg::SLEEP_CNT_W'(poll_pkg::STARTUP_BASE));
  wire check_entry = (state_ff == poll_pkg::ST_STARTUP) && start_done;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_tcnt  = tcnt_ff;
    nxt_cv    = cv_ff;
    nxt_pass  = pass_ff;
    case (state_ff)
      poll_pkg::ST_SLEEP:
      begin
        if (sleep_written_ff)
          nxt_tcnt = '0;
        else if (sleep_done)
        begin
          nxt_state = poll_pkg::ST_STARTUP;
          nxt_tcnt  = '0;
        end
        else if (base_tick && !forever_sl)
          nxt_tcnt = tcnt_ff + 1'b1;
      end
      poll_pkg::ST_STARTUP:
      begin
        if (start_done)
        begin
          nxt_tcnt = '0;
          nxt_cv   = '0;
          nxt_pass = 5'h00;
          if (checks_needed == poll_pkg::CHECKS_0)
            nxt_state = poll_pkg::ST_RECEIVE;
          else
            nxt_state = poll_pkg::ST_CHECK;
        end
        else if (base_tick)
          nxt_tcnt = tcnt_ff + 1'b1;
      end
      poll_pkg::ST_CHECK:
      begin
        if (ext_tick)
        begin
          if (edge_seen && below_min)
            nxt_state = poll_pkg::ST_SLEEP;
          // An edge on the tick that reaches the upper limit is already too late
          else if (at_max)
            nxt_state = poll_pkg::ST_SLEEP;
          else if (edge_seen)
          begin
            nxt_cv   = '0;
            nxt_pass = pass_ff + 5'h01;
            if (pass_ff + 5'h01 >= checks_needed)
              nxt_state = poll_pkg::ST_RECEIVE;
          end
          else
            nxt_cv = cv_inc;
        end
      end
      poll_pkg::ST_RECEIVE:
      begin
        if (return_poll_i)
        begin
          nxt_state = poll_pkg::ST_SLEEP;
          nxt_tcnt  = '0;
        end
      end
      default: nxt_state = poll_pkg::ST_SLEEP;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n)
    if (!rst_n)
    begin
      state_ff   <= poll_pkg::ST_SLEEP;
      tcnt_ff    <= '0;
      cv_ff      <= '0;
      pass_ff    <= 5'h00;
      demod_q_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      tcnt_ff  <= nxt_tcnt;
      cv_ff    <= nxt_cv;
      pass_ff  <= nxt_pass;
      // Reference taken again on entry to the check, so that a stale
      // start-up sample cannot pose as the first edge
      if (ext_tick || check_entry)
        demod_q_ff <= demod_i;
    end

  wire active = (state_ff != poll_pkg::ST_SLEEP);

  logic [7:0] rdata_ff;
  logic       act_ff;
  logic       en_ff;
  logic       rx_ff;
  logic       data_ff;
  wire  [7:0] rd_mux = (reg_addr_i == poll_pkg::ADDR_CONFIG)    ? cfg_ff :
                       (reg_addr_i == poll_pkg::ADDR_LIMIT_MIN) ? {3'h0, lim_min_ff} :
                       (reg_addr_i == poll_pkg::ADDR_LIMIT_MAX) ? {3'h0, lim_max_ff} :
                       {1'b0, state_ff, sleep_ff};

  always_ff @(posedge clock_i or negedge rst_n)
    if (!rst_n)
    begin
      rdata_ff <= 8'h00;
      act_ff   <= 1'b0;
      en_ff    <= 1'b0;
      rx_ff    <= 1'b0;
      data_ff  <= 1'b1;
    end
    else
    begin
      rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
      act_ff   <= active;
      en_ff    <= active;
      rx_ff    <= (state_ff == poll_pkg::ST_RECEIVE);
      data_ff  <= (state_ff == poll_pkg::ST_RECEIVE) ? demod_i : 1'b1;
    end

  assign reg_rdata_o          = rdata_ff;
  assign activity_indicator_o = act_ff;
  assign signal_enable_o      = en_ff;
  assign receiving_o          = rx_ff;
  assign data_o               = data_ff;

  sleep_gate_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_ff == poll_pkg::ST_SLEEP) |=> !en_ff)
    else $error("processing enabled while asleep");
  forever_sleep_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_ff == poll_pkg::ST_SLEEP && forever_sl && !sleep_written_ff)
      |=> (state_ff == poll_pkg::ST_SLEEP))
    else $error("left permanent sleep");
  indicator_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    act_ff == $past(active))
    else $error("activity indicator mismatch");
  too_short_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_ff == poll_pkg::ST_CHECK && edge_seen && below_min)
      |=> (state_ff == poll_pkg::ST_SLEEP))
    else $error("short interval not aborted");
  too_long_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_ff == poll_pkg::ST_CHECK && ext_tick && at_max)
      |=> (state_ff == poll_pkg::ST_SLEEP))
    else $error("long interval not aborted");
  restart_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_ff == poll_pkg::ST_CHECK && edge_seen && !below_min && !at_max) |=> (cv_ff == '0))
    else $error("counter not restarted at edge");
  zero_bits_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_ff == poll_pkg::ST_STARTUP && start_done && checks_needed == 5'h00)
      |=> (state_ff == poll_pkg::ST_RECEIVE))
    else $error("zero checks did not enter receive");
  order_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_ff == poll_pkg::ST_SLEEP) |=> (state_ff inside {poll_pkg::ST_SLEEP,
                                                          poll_pkg::ST_STARTUP}))
    else $error("sleep skipped start-up");
  data_route_a : assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_ff != poll_pkg::ST_RECEIVE) |=> data_ff)
    else $error("data routed outside receive");

  wake_c : cover property (@(posedge clock_i) disable iff (!rst_n)
    state_ff == poll_pkg::ST_SLEEP ##1 state_ff == poll_pkg::ST_STARTUP);
  receive_c : cover property (@(posedge clock_i) disable iff (!rst_n)
    state_ff == poll_pkg::ST_CHECK ##1 state_ff == poll_pkg::ST_RECEIVE);
  fail_c : cover property (@(posedge clock_i) disable iff (!rst_n)
    state_ff == poll_pkg::ST_CHECK ##1 state_ff == poll_pkg::ST_SLEEP);
endmodule
`default_nettype wire

// ---- pkg/poll_pkg.sv ----
// Purpose: Shared constants of the polling and bit-check controller
// Assumes: One 125 MHz system clock; base clock made by a counter
// Notes:   Base periods are given in ns and turned into cycle counts here; start-up and sleep times in base periods, limits in extended periods
package poll_pkg;

  localparam int    CLK_PERIOD_NS      = 8;
  // Base clock periods per mode-select level, in ns
  localparam real   BASE_PERIOD_LO_NS  = 2038.3;
  localparam real   BASE_PERIOD_HI_NS  = 2069.7;
  localparam int    BASE_DIV_LO        = int'(BASE_PERIOD_LO_NS / CLK_PERIOD_NS);
  localparam int    BASE_DIV_HI        = int'(BASE_PERIOD_HI_NS / CLK_PERIOD_NS);
  localparam int    DIV_W              = 9;

  localparam logic [1:0] RANGE_0       = 2'h0;
  localparam logic [1:0] RANGE_1       = 2'h1;
  localparam logic [1:0] RANGE_2       = 2'h2;
  localparam logic [1:0] RANGE_3       = 2'h3;
  localparam logic [3:0] XCLK_DIV_0    = 4'h8;
  localparam logic [3:0] XCLK_DIV_1    = 4'h4;
  localparam logic [3:0] XCLK_DIV_2    = 4'h2;
  localparam logic [3:0] XCLK_DIV_3    = 4'h1;

  localparam int    SLEEP_W            = 5;
  localparam logic [4:0] SLEEP_FOREVER = 5'h1f;
  localparam int    SLEEP_UNIT_BASE    = 1024;
  localparam logic [3:0] SLEEP_FACTOR_STD = 4'h1;
  localparam logic [3:0] SLEEP_FACTOR_EXT = 4'h8;
  localparam int    SLEEP_CNT_W        = 18;

  localparam int    LIMIT_W            = 5;
  localparam int    CV_W               = 6;
  localparam logic [4:0] CHECKS_0      = 5'h00;
  localparam logic [4:0] CHECKS_3      = 5'h06;
  localparam logic [4:0] CHECKS_6      = 5'h0c;
  localparam logic [4:0] CHECKS_9      = 5'h12;
  localparam logic [4:0] LIM_MIN_RST   = 5'h0e;
  localparam logic [4:0] LIM_MAX_RST   = 5'h18;

  // Register indices on the register port
  localparam logic [1:0] ADDR_CONFIG    = 2'h0;
  localparam logic [1:0] ADDR_LIMIT_MIN = 2'h1;
  localparam logic [1:0] ADDR_LIMIT_MAX = 2'h2;
  localparam logic [1:0] ADDR_STATUS    = 2'h3;

  // Start-up settling length, in base clock periods
  localparam logic [7:0] STARTUP_BASE  = 8'h10;

  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_STARTUP,
    ST_CHECK,
    ST_RECEIVE
  } poll_state_e;

endpackage

// ---- tb/demod_source.sv ----
// Purpose: Demodulator output model facing the polling controller
// Assumes: Bench changes the mode right after a rising edge
// Notes:   Noise mode stands in for the unsettled output during start-up
`timescale 1ns/10ps
`default_nettype none
module demod_source
(
  input  wire logic        clock_i,  // System clock
  input  wire logic        noise_i,  // Toggle every cycle
  input  wire logic [15:0] period_i, // Cycles between edges, 0 holds
  input  wire logic        level_i,  // Level while holding
  output logic             demod_o   // Demodulator output
);
  logic [15:0] cnt_ff;

  initial cnt_ff = 16'h0000;
  initial demod_o = 1'b1;

  always @(posedge clock_i)
  begin
    if (noise_i)
    begin
      demod_o <= ~demod_o;
      cnt_ff  <= 16'h0000;
    end
    else if (period_i == 16'h0000)
    begin
      demod_o <= level_i;
      cnt_ff  <= 16'h0000;
    end
    else if (cnt_ff == period_i - 16'h0001)
    begin
      demod_o <= ~demod_o;
      cnt_ff  <= 16'h0000;
    end
    else
      cnt_ff <= cnt_ff + 16'h0001;
  end
endmodule
`default_nettype wire

// ---- tb/polling_bit_check_controller_tb.sv ----
// Purpose: Self-checking bench of the polling and bit-check controller
// Assumes: Mode pin low and baud range 3 first; mode high for the range sweep
// Notes:   Sleep field 0 gives fast polls; long sleeps do not fit the run
`timescale 1ns/10ps
`default_nettype none
module polling_bit_check_controller_tb;
  localparam int TK = poll_pkg::BASE_DIV_LO;
  localparam int TKH = poll_pkg::BASE_DIV_HI;
  localparam int SU = int'(poll_pkg::STARTUP_BASE);
  localparam int LMIN = 19;
  localparam int LMAX = 24;
  localparam logic [7:0] RST [4] = '{8'h00, 8'h0e, 8'h18, 8'h1f};

  logic        clock_i;
  logic        reset_n_i;
  logic        mode_sel;
  logic        ret_poll;
  logic        reg_wr;
  logic        reg_rd;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        noise;
  logic        level;
  logic [15:0] period;
  wire logic   demod;
  wire logic [7:0] rdata;
  wire logic   activity;
  wire logic   sig_en;
  wire logic   receiving;
  wire logic   data;
  int          miscompares;
  int          checks;
  int          seed;
  int          cyc;
  int          n;
  int          p;
  int          tk;
  logic [7:0]  d;
  logic [7:0]  q;

  polling_bit_check_controller dut
  (
    .clock_i              (clock_i),
    .reset_n_i            (reset_n_i),
    .mode_sel_i           (mode_sel),
    .demod_i              (demod),
    .return_poll_i        (ret_poll),
    .reg_addr_i           (reg_addr),
    .reg_wdata_i          (reg_wdata),
    .reg_wr_i             (reg_wr),
    .reg_rd_i             (reg_rd),
    .reg_rdata_o          (rdata),
    .activity_indicator_o (activity),
    .signal_enable_o      (sig_en),
    .receiving_o          (receiving),
    .data_o               (data)
  );

  demod_source src
  (
    .clock_i  (clock_i),
    .noise_i  (noise),
    .period_i (period),
    .level_i  (level),
    .demod_o  (demod)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  always @(posedge clock_i) cyc <= cyc + 1;

  function automatic logic [7:0] mask5(input logic [7:0] v);
    return {3'h0, v[4:0]};
  endfunction

  function automatic logic [7:0] status_exp(input logic [1:0] st, input logic [4:0] sl);
    return {1'b0, st, sl};
  endfunction

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock_i);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clock_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock_i);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Polls until the chosen output reaches the level, or gives up
  task automatic wait_for(input logic sel, input logic val, input int max);
    int i;
    for (i = 0; i < max; i++)
    begin
      @(posedge clock_i);
      #1;
      if ((sel ? receiving : activity) === val)
        return;
    end
    miscompares++;
    $display("[ERR] wait expected %b seen timeout", val);
    stop_test();
  endtask

  // One poll from sleep 0, parked at sleep 31 afterwards; n counts from wake-up
  task automatic run_poll(input int per, input logic want_rx);
    int t0;
    wr(2'h3, 8'h00);
    wait_for(1'b0, 1'b1, 4 * tk);
    t0 = cyc;
    wr(2'h3, 8'h1f);
    noise <= 1'b1;
    repeat ((SU - 2) * tk) @(posedge clock_i);
    check("early_rx", receiving, 1'b0);
    noise <= 1'b0;
    repeat (2 * tk) @(posedge clock_i);
    period <= 16'(per * tk);
    wait_for(want_rx, want_rx, 160 * tk);
    n = cyc - t0;
    period <= 16'h0000;
  endtask

  task automatic back_to_poll();
    @(posedge clock_i);
    ret_poll <= 1'b1;
    @(posedge clock_i);
    ret_poll <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask

  initial
  begin
    reset_n_i = 1'b0;
    mode_sel  = 1'b0;
    tk        = TK;
    ret_poll  = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 2'h0;
    reg_wdata = 8'h00;
    noise     = 1'b0;
    level     = 1'b1;
    period    = 16'h0000;
    miscompares = 0;
    checks    = 0;
    cyc       = 0;
    seed      = 32'hc2fc;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    check("act_rst", activity, 1'b0);
    check("data_rst", data, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      rd(2'(i), q);
      check("reg_rst", q, RST[i]);
    end
    d = 8'($random(seed));
    wr(2'h1, d);
    rd(2'h1, q);
    check("lim_min", q, mask5(d));
    wr(2'h2, ~d);
    rd(2'h2, q);
    check("lim_max", q, mask5(~d));
    wr(2'h1, 8'(LMIN));
    wr(2'h2, 8'(LMAX));
    wr(2'h0, 8'h03);
    run_poll(0, 1'b1);
    check("rx_bits0", 32'(n >= SU * TK - 8 && n <= (SU + 1) * TK + 8), 32'h1);
    rd(2'h3, q);
    check("status_rx", q, status_exp(2'h3, 5'h1f));
    for (int k = 0; k < 3; k++)
    begin
      level <= 1'($random(seed));
      repeat (3 * TK) @(posedge clock_i);
      check("data_rx", data, level);
    end
    check("en_rx", sig_en, 1'b1);
    back_to_poll();
    check("rx_off", receiving, 1'b0);
    repeat (8 * TK) @(posedge clock_i);
    check("act_perm", activity, 1'b0);
    check("en_perm", sig_en, 1'b0);
    wr(2'h0, 8'h07);
    run_poll(0, 1'b0);
    check("t_max", 32'(n >= (SU + LMAX - 2) * TK && n <= (SU + LMAX + 1) * TK), 32'h1);
    run_poll(5, 1'b0);
    check("t_short", 32'(n < (SU + LMIN) * TK), 32'h1);
    rd(2'h3, q);
    check("status_sl", q, status_exp(2'h0, 5'h1f));
    p = 19 + int'($unsigned($random(seed)) % 4);
    run_poll(p, 1'b1);
    check("t_pass", 32'(n >= (SU + 6 * p - 2) * TK && n <= (SU + 6 * p + 2) * TK), 32'h1);
    back_to_poll();
    check("rx_end", receiving, 1'b0);
    // Range sweep on the other mode level; a tight upper limit keeps the
    // slow ranges short, and the timeout lands on whole base periods
    wr(2'h2, 8'h02);
    mode_sel <= 1'b1;
    tk = TKH;
    for (int r = 0; r < 3; r++)
    begin
      wr(2'h0, 8'h04 | 8'(r));
      run_poll(0, 1'b0);
      check("t_range", 32'(n % tk == 0 && n / tk > SU + (8 >> r) &&
                           n / tk <= SU + 2 * (8 >> r)), 32'h1);
    end
    stop_test();
  end
endmodule
`default_nettype wire
